/* File: tcc_defines.svh */
// Constants of the sixteen-bit timer clock core: widths, reset values and cycle counts.
// How it works
// RULE1: The count is sixteen bits wide, read as a high and a low byte, and a write to either byte replaces that byte at once.
// RULE2: Nothing counts while counter_run is clear, and with it set the count runs freely unless gate_enable asks for the gate to permit each count.
// RULE3: The two-bit clock_source_select picks the low-frequency oscillator, the crystal or the external pin, the system clock, or the instruction clock.
// RULE4: The instruction clock advances the count once every four system cycles, and the system clock advances it on every cycle.
// RULE5: With the external pin selected and counting on, each rising edge of ext_clock_in is a count.
// RULE6: An external source must show a falling edge before its first counted rising edge after reset, a counter write, or any time spent disabled.
// RULE7: The prescaler divides the chosen clock by 1, 2, 4 or 8 according to prescale_select.
// RULE8: The prescale counter is hidden from software and is cleared by every write to either counter byte.
// RULE9: Setting crystal_osc_enable starts the crystal driver, which keeps running while the processor sleeps.
// RULE10: With sync_disable set the external clock skips the synchronizer, and with it clear the clock is synchronized first.
// RULE11: In asynchronous mode with an external source the count keeps running in sleep and an overflow raises a wake request.
// RULE12: Changing the synchronization mode may lose one count or add one count.
// RULE13: Software waits for the crystal to settle, for instance by presetting the count to FC00h and waiting 1024 counts for the overflow flag.
// RULE14: Software that wants full resolution on the system clock gates the count with an asynchronous event on the gate pin.
// RULE15: A roll from FFFFh to 0000h sets overflow_flag, which software clears.
// RULE16: In asynchronous mode a read of either byte while counting still returns a whole, valid value.
// RULE17: In synchronous mode the external edge passes a multi-stage synchronizer on the system clock and gives a one-cycle count enable.
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH

// ============================================================
// Widths and reset values
`define TCC_COUNT_WIDTH      16
`define TCC_BYTE_WIDTH       8
`define TCC_COUNT_RESET      16'h0000
`define TCC_COUNT_ALL_ONES   16'hFFFF
`define TCC_PRESCALE_WIDTH   3

// ============================================================
// Timing
`define TCC_CLOCK_PERIOD_NS  5
`define TCC_SYSTEM_PER_INSTR 4
`define TCC_PHASE_WIDTH      2
`define TCC_PHASE_LAST       2'h3

`endif

/* File: tcc_pkg.sv */
// Types shared by the sixteen-bit timer clock core.
package tcc_pkg;

  // ============================================================
  // Clock source selection codes
  typedef enum logic [1:0] {
    tcc_src_instruction = 2'h0,
    tcc_src_system      = 2'h1,
    tcc_src_external    = 2'h2,
    tcc_src_low_freq    = 2'h3
  } tcc_source_t;

  // ============================================================
  // Prescale ratio codes
  typedef enum logic [1:0] {
    tcc_div_1 = 2'h0,
    tcc_div_2 = 2'h1,
    tcc_div_4 = 2'h2,
    tcc_div_8 = 2'h3
  } tcc_prescale_t;

endpackage : tcc_pkg

/* File: tcc_tick_if.sv */
// Interface carrying source ticks into the prescaler and its divided ticks back.
`timescale 1ns/10ps
`default_nettype none
interface tcc_tick_if;
  import tcc_pkg::*;
  logic          tick;
  logic          clear;
  tcc_prescale_t ratio;
  logic          divided;

  modport core (output tick, output clear, output ratio, input divided);
  modport scaler (input tick, input clear, input ratio, output divided);
endinterface : tcc_tick_if
`default_nettype wire

/* File: tcc_edge_detect.sv */
// Edge detector with a selectable two-stage synchronizer in front.
`timescale 1ns/10ps
`default_nettype none
module tcc_edge_detect
  import tcc_pkg::*;
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_b,
  // Source level and mode
  input  wire logic level,
  input  wire logic bypass,
  // Edge pulses
  output logic      rise,
  output logic      fall
);
  logic sync1;
  logic sync2;
  logic chosen;
  logic prev;

  // ============================================================
  // Synchronizer
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= level;
      sync2 <= sync1;
    end
  end

  // Switching the bypass changes the history depth, so one edge may be missed or repeated.
  assign chosen = bypass ? level : sync2; // see RULE10 see RULE12

  // ============================================================
  // Edge history
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prev <= 1'b0;
    end else begin
      prev <= chosen;
    end
  end

  assign rise = chosen & ~prev; // see RULE17
  assign fall = ~chosen & prev;
endmodule : tcc_edge_detect
`default_nettype wire

/* File: tcc_prescaler.sv */
// Hidden divide-by-1/2/4/8 prescaler on the source ticks.
`timescale 1ns/10ps
`default_nettype none
`include "tcc_defines.svh"
module tcc_prescaler
  import tcc_pkg::*;
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_b,
  // Tick path
  tcc_tick_if.scaler ticks
);
  logic [`TCC_PRESCALE_WIDTH-1:0] count;
  logic [`TCC_PRESCALE_WIDTH-1:0] last;

  always_comb begin
    unique case (ticks.ratio)
      tcc_div_1: last = 3'h0;
      tcc_div_2: last = 3'h1;
      tcc_div_4: last = 3'h3;
      tcc_div_8: last = 3'h7;
    endcase
  end

  // ============================================================
  // Divider count
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count <= 3'h0;
    end else if (ticks.clear) begin
      count <= 3'h0; // see RULE8
    end else if (ticks.tick) begin
      count <= (count >= last) ? 3'h0 : count + 3'h1; // see RULE7
    end
  end

  assign ticks.divided = ticks.tick & (count >= last); // see RULE7
endmodule : tcc_prescaler
`default_nettype wire

/* File: tcc_core.sv */
// Sixteen-bit timer clock core: source selection, prescaling and the count itself.
`timescale 1ns/10ps
`default_nettype none
`include "tcc_defines.svh"
module tcc_core
  import tcc_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // Control bits
  input  wire logic        counter_run,
  input  wire logic        gate_enable,
  input  wire logic        gate_permit,
  input  wire logic [1:0]  clock_source_select,
  input  wire logic        crystal_osc_enable,
  input  wire logic [1:0]  prescale_select,
  input  wire logic        sync_disable,
  input  wire logic        sleep_mode,
  // Counter byte writes
  input  wire logic        write_high,
  input  wire logic        write_low,
  input  wire logic [7:0]  write_data,
  // Overflow flag clear
  input  wire logic        overflow_clear,
  // Clock pins and oscillators
  input  wire logic        ext_clock_in,
  input  wire logic        low_freq_internal_osc,
  input  wire logic        crystal_in_pin,
  output logic             crystal_out_pin,
  output logic             crystal_out_oe,
  // Count and status
  output logic [7:0]       count_high_byte,
  output logic [7:0]       count_low_byte,
  output logic             overflow_flag,
  output logic             overflow_pulse,
  output logic             wake_request
);
  tcc_tick_if ticks ();

  tcc_source_t                     source;
  logic [`TCC_PHASE_WIDTH-1:0]     phase;
  logic                            instr_tick;
  logic                            ext_level;
  logic                            is_external;
  logic                            ext_rise;
  logic                            ext_fall;
  logic                            lf_rise;
  logic                            armed;
  logic                            enabled;
  logic                            allowed;
  logic                            source_tick;
  logic                            any_write;
  logic [`TCC_COUNT_WIDTH-1:0]     count;
  logic [`TCC_COUNT_WIDTH-1:0]     next_count;
  logic                            step;
  logic                            roll;

  assign source    = tcc_source_t'(clock_source_select);
  assign any_write = write_high | write_low;

  // ============================================================
  // Instruction clock phase
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  assign instr_tick = (phase == `TCC_PHASE_LAST); // see RULE4

  // ============================================================
  // Crystal driver
  // The inverting driver is held on in sleep, so a crystal source survives a sleep period.
  assign crystal_out_oe  = crystal_osc_enable; // see RULE9
  assign crystal_out_pin = crystal_osc_enable & ~crystal_in_pin; // see RULE9

  // ============================================================
  // External source and edges
  assign ext_level   = crystal_osc_enable ? crystal_in_pin : ext_clock_in; // see RULE3
  assign is_external = (source == tcc_src_external);

  tcc_edge_detect u_ext_edge (
    .clock  (clock),
    .rst_b  (rst_b),
    .level  (ext_level),
    .bypass (sync_disable),
    .rise   (ext_rise),
    .fall   (ext_fall)
  );

  tcc_edge_detect u_lf_edge (
    .clock  (clock),
    .rst_b  (rst_b),
    .level  (low_freq_internal_osc),
    .bypass (1'b0),
    .rise   (lf_rise),
    .fall   ()
  );

  // ============================================================
  // Count enable
  assign enabled = counter_run & (~gate_enable | gate_permit); // see RULE2
  // Only an asynchronous external count may advance while the processor sleeps.
  assign allowed = enabled & (~sleep_mode | (sync_disable & is_external)); // see RULE11

  // A falling edge must be seen before the first rising edge is counted.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      armed <= 1'b0;
    end else if (any_write || !counter_run) begin
      armed <= 1'b0; // see RULE6
    end else if (ext_fall) begin
      armed <= 1'b1; // see RULE6
    end
  end

  always_comb begin
    unique case (source)
      tcc_src_instruction: source_tick = instr_tick; // see RULE4
      tcc_src_system:      source_tick = 1'b1; // see RULE4
      tcc_src_external:    source_tick = ext_rise & armed; // see RULE5 see RULE6
      tcc_src_low_freq:    source_tick = lf_rise; // see RULE3
    endcase
  end

  // ============================================================
  // Prescaler
  assign ticks.tick  = source_tick & allowed;
  assign ticks.clear = any_write; // see RULE8
  assign ticks.ratio = tcc_prescale_t'(prescale_select);

  tcc_prescaler u_prescaler (
    .clock (clock),
    .rst_b (rst_b),
    .ticks (ticks.scaler)
  );

  // ============================================================
  // Counter
  assign step = ticks.divided;
  assign roll = step & (count == `TCC_COUNT_ALL_ONES) & ~any_write;

  always_comb begin
    next_count = count;
    if (step) begin
      next_count = count + 16'h0001;
    end
    // A write takes the byte it names and lets the other byte keep its running value.
    if (write_high) begin
      next_count[15:8] = write_data; // see RULE1
    end
    if (write_low) begin
      next_count[7:0] = write_data; // see RULE1
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count <= `TCC_COUNT_RESET;
    end else begin
      count <= next_count; // see RULE1
    end
  end

  // Both bytes come from the one register, so a read never sees a half-carried value.
  assign count_high_byte = count[15:8]; // see RULE16
  assign count_low_byte  = count[7:0]; // see RULE16

  // ============================================================
  // Overflow flag, set wins over clear
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      overflow_flag <= 1'b0;
    end else if (roll) begin
      overflow_flag <= 1'b1; // see RULE15
    end else if (overflow_clear) begin
      overflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      overflow_pulse <= 1'b0;
      wake_request   <= 1'b0;
    end else begin
      overflow_pulse <= roll; // see RULE15
      wake_request   <= roll & sleep_mode; // see RULE11
    end
  end

endmodule : tcc_core
`default_nettype wire

/* File: tcc_clock_source.sv */
// Far-side clock source model: external pin, crystal or slow oscillator.
`timescale 1ns/10ps
`default_nettype none
module tcc_clock_source (
  // Clock and burst request
  input wire logic       clock,
  input wire logic       en,
  input wire logic [3:0] half,
  // Source level
  output logic           level
);
  logic [3:0] ticks;

  // Idle low between bursts, so every burst opens with a rise and no fall yet.
  always @(posedge clock) begin
    ticks <= (!en || ticks == half - 4'h1) ? 4'h0 : ticks + 4'h1;
    level <= en && (level ^ (ticks == half - 4'h1));
  end
endmodule : tcc_clock_source
`default_nettype wire

/* File: tcc_core_assertions.sv */
// Port-level assertions for the timer clock core.
`timescale 1ns/10ps
`default_nettype none
module tcc_core_assertions (
  // Clock, reset and controls
  input wire logic       clock,
  input wire logic       rst_b,
  input wire logic       counter_run,
  input wire logic       gate_enable,
  input wire logic       gate_permit,
  input wire logic [1:0] clock_source_select,
  input wire logic [1:0] prescale_select,
  input wire logic       sleep_mode,
  input wire logic       write_high,
  input wire logic       write_low,
  input wire logic [7:0] write_data,
  input wire logic       overflow_clear,
  // Count and status
  input wire logic [7:0] count_high_byte,
  input wire logic [7:0] count_low_byte,
  input wire logic       overflow_flag,
  input wire logic       overflow_pulse,
  input wire logic       wake_request
);
  wire logic [15:0] cnt = {count_high_byte, count_low_byte};
  wire logic        wr  = write_high | write_low;

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  chk_stop_holds: assert property (!counter_run && !wr |=> $stable(cnt))
    else $error("count moved while stopped");
  chk_gate_holds: assert property (
    counter_run && gate_enable && !gate_permit && !wr |=> $stable(cnt))
    else $error("count moved with gate shut");
  chk_fast_step: assert property (
    counter_run && !gate_enable && !sleep_mode && !wr && clock_source_select == 2'h1
    && prescale_select == 2'h0 |=> cnt == $past(cnt) + 16'h0001)
    else $error("system clock step missed");
  chk_low_write: assert property (write_low |=> count_low_byte == $past(write_data))
    else $error("low byte not loaded");
  chk_high_write: assert property (write_high |=> count_high_byte == $past(write_data))
    else $error("high byte not loaded");
  chk_roll_flags: assert property (
    cnt == 16'hFFFF && !wr ##1 cnt == 16'h0000 |-> overflow_flag && overflow_pulse)
    else $error("roll gave no flag");
  chk_flag_sticks: assert property (overflow_flag && !overflow_clear |=> overflow_flag)
    else $error("flag fell without clear");
  chk_wake_sleep: assert property (
    overflow_pulse || wake_request |-> overflow_pulse && wake_request == $past(sleep_mode))
    else $error("wake request wrong");

  cover property (overflow_pulse && wake_request);
  cover property (write_high && write_low);
  cover property (counter_run && gate_enable && !gate_permit);
endmodule : tcc_core_assertions

bind tcc_core tcc_core_assertions tcc_core_assertions_inst (.*);
`default_nettype wire

/* File: testbench.sv */
// Self-checking testbench for the timer clock core.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        clock, rst_b, counter_run, gate_enable, gate_permit, crystal_osc_enable;
  logic        sync_disable, sleep_mode, write_high, write_low, overflow_clear, src_run;
  logic        ext_clock_in, low_freq_internal_osc, crystal_in_pin, crystal_out_pin;
  logic        crystal_out_oe, overflow_flag, overflow_pulse, wake_request;
  logic        wake_seen = 1'b0;
  logic [1:0]  clock_source_select, prescale_select;
  logic [7:0]  write_data, count_high_byte, count_low_byte;
  int          error_cnt = 0, n_checks = 0, cycles = 0;
  wire  logic [15:0] cnt = {count_high_byte, count_low_byte};

  tcc_core tcc_core_inst (.*);
  tcc_clock_source tcc_clock_source_inst (.clock(clock), .en(src_run), .half(4'h3),
                                          .level(ext_clock_in));
  tcc_clock_source xtal_inst (.clock(clock), .en(src_run & crystal_out_oe), .half(4'h2),
                              .level(crystal_in_pin));
  tcc_clock_source lfo_inst (.clock(clock), .en(src_run), .half(4'h2),
                             .level(low_freq_internal_osc));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles    <= cycles + 1;
    wake_seen <= wake_seen | wake_request;
    if (cycles == 10000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  task automatic load(input logic [15:0] v);
    {write_high, write_data} = {1'b1, v[15:8]};
    step(1);
    {write_high, write_low, write_data} = {2'b01, v[7:0]};
    step(1);
    write_low = 1'b0;
  endtask : load

  // Counter runs len + 8 edges; the tail lets synchronized source edges land.
  task automatic t_src(input logic [1:0] src, input logic sd, input logic [15:0] v,
                       input int len, input logic [15:0] exp);
    clock_source_select = src;
    {sync_disable, sleep_mode} = {sd, sd};
    load(v);
    {counter_run, src_run} = 2'b11;
    step(len);
    src_run = 1'b0;
    step(8);
    counter_run = 1'b0;
    step(1);
    chk(cnt, exp);
  endtask : t_src

  task automatic t_write;
    load(16'hCDAB);
    chk(cnt, 16'hCDAB);
    {write_high, write_low, write_data} = {2'b11, 8'h5A};
    step(1);
    {write_high, write_low} = 2'b00;
    chk(cnt, 16'h5A5A);
    step(1);
  endtask : t_write

  task automatic t_rates;
    for (int s = 0; s < 2; s++) begin
      for (int p = 0; p < 4; p++) begin
        prescale_select = p[1:0];
        t_src(s[1:0], 1'b0, 16'h0000, 56, 16'(64 >> (p + 2 - 2 * s)));
      end
    end
  endtask : t_rates

  task automatic t_gate;
    {gate_enable, gate_permit, prescale_select} = 4'b1000;
    t_src(2'h1, 1'b0, 16'h0000, 8, 16'h0000);
    gate_permit = 1'b1;
    t_src(2'h1, 1'b0, 16'h0000, 8, 16'h0010);
    t_src(2'h1, 1'b1, 16'h0000, 8, 16'h0000);
    gate_enable = 1'b0;
  endtask : t_gate

  task automatic t_xtal;
    crystal_osc_enable = 1'b1;
    t_src(2'h2, 1'b1, 16'hFC00, 4100, 16'h0000);
    chk({15'h0000, overflow_flag}, 16'h0001);
    chk({15'h0000, wake_seen}, 16'h0001);
    chk({14'h0, crystal_out_oe, crystal_out_pin}, 16'h0003);
    overflow_clear = 1'b1;
    crystal_osc_enable = 1'b0;
    step(1);
    overflow_clear = 1'b0;
    chk({15'h0000, overflow_flag}, 16'h0000);
    chk({14'h0, crystal_out_oe, crystal_out_pin}, 16'h0000);
  endtask : t_xtal

  task automatic test_done;
    $display("%0d checks, %0d errors", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  initial begin
    {rst_b, counter_run, gate_enable, gate_permit, crystal_osc_enable, sync_disable} = '0;
    {sleep_mode, write_high, write_low, overflow_clear, src_run} = '0;
    {clock_source_select, prescale_select, write_data} = '0;
    step(20);
    rst_b = 1'b1;
    step(4);
    t_write();
    t_rates();
    t_gate();
    t_src(2'h2, 1'b0, 16'h0000, 24, 16'h0003);
    t_src(2'h2, 1'b1, 16'h0000, 24, 16'h0003);
    t_src(2'h3, 1'b0, 16'h0000, 24, 16'h0006);
    t_xtal();
    test_done();
  end
endmodule : testbench
`default_nettype wire
